// >>> src/hdc_config_bits.sv
// Hub device configuration byte: straps, EEPROM load, SMBus write, link PM and power
`timescale 1ns/1ps
`default_nettype none
`include "hdc_regs.svh"

module hdc_config_bits #(
   parameter int DOWN_PORTS = `HDC_DOWN_PORTS,
   parameter int TMO_W      = `HDC_TIMEOUT_WIDTH
) (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // Strap pins
   input  wire logic                          gang_strap_pin,
   input  wire logic                          power_report_strap_pin,
   // Configuration source
   input  wire hdc_pkg::hdc_mode_type         cfg_mode,
   input  wire logic                          eeprom_load_valid,
   input  wire logic [`HDC_CFG_WIDTH-1:0]     eeprom_load_data,
   input  wire logic                          smbus_write,
   input  wire logic [`HDC_CFG_WIDTH-1:0]     smbus_write_data,
   output logic      [`HDC_CFG_WIDTH-1:0]     smbus_read_data,
   output logic                               cfg_ready,
   // Configuration bits as seen by the rest of the hub
   output logic                               serial_string_writable,
   output logic                               link_low_power_disable,
   output logic                               low_power_timeout_override,
   // Link power management
   input  wire logic                          force_accept_lmp,
   input  wire logic                          upstream_disconnect,
   input  wire logic [DOWN_PORTS:0]           lp_request_in,
   input  wire logic [DOWN_PORTS:0]           lp_initiate_want,
   output logic      [DOWN_PORTS:0]           lp_request_accept,
   output logic      [DOWN_PORTS:0]           lp_initiate_go,
   output logic                               lp_forced,
   // Downstream U1/U2 timeouts
   input  wire logic                          timeout_feature_enable,
   input  wire logic                          host_timeout_write,
   input  wire logic [$clog2(DOWN_PORTS)-1:0] host_timeout_port,
   input  wire logic [TMO_W-1:0]              host_timeout_value,
   output logic      [DOWN_PORTS*TMO_W-1:0]   effective_timeout,
   // Port power
   input  wire logic [DOWN_PORTS-1:0]         port_power_request,
   output logic      [DOWN_PORTS-1:0]         port_power_enable_pins,
   output logic                               power_status_report_en
);

   hdc_pkg::hdc_cfg_state_type state_q;

   logic serial_wr_q;
   logic lp_disable_q;
   logic gang_q;
   logic report_n_q;
   logic tmo_ovr_q;

   logic load_take;
   logic smbus_take;
   logic [`HDC_CFG_WIDTH-1:0] read_d;

   // Sequencing: straps first, then the EEPROM image in I2C mode, then ready
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= hdc_pkg::HDC_CFG_STRAP;
      end else begin
         case (state_q)
            hdc_pkg::HDC_CFG_STRAP: begin
               if (cfg_mode == hdc_pkg::HDC_MODE_I2C) begin
                  state_q <= hdc_pkg::HDC_CFG_LOAD;
               end else begin
                  state_q <= hdc_pkg::HDC_CFG_READY;
               end
            end
            hdc_pkg::HDC_CFG_LOAD: begin
               if (eeprom_load_valid) begin
                  state_q <= hdc_pkg::HDC_CFG_READY;
               end
            end
            hdc_pkg::HDC_CFG_READY: begin
               state_q <= hdc_pkg::HDC_CFG_READY;
            end
            default: state_q <= hdc_pkg::HDC_CFG_STRAP;
         endcase
      end
   end

   // A later EEPROM image in I2C mode is still honoured, e.g. an in-system reload
   assign load_take  = eeprom_load_valid && (cfg_mode == hdc_pkg::HDC_MODE_I2C)
                       && (state_q != hdc_pkg::HDC_CFG_STRAP);
   // SMBus writes wait for the strap capture so a strap never undoes a host write
   assign smbus_take = smbus_write && (cfg_mode == hdc_pkg::HDC_MODE_SMBUS)
                       && (state_q != hdc_pkg::HDC_CFG_STRAP);

   // Strap-backed bits: pins are caught in the first cycle after reset release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gang_q     <= `HDC_RST_GANG;
         report_n_q <= `HDC_RST_REPORT_DISABLE_N;
      end else if (state_q == hdc_pkg::HDC_CFG_STRAP) begin
         gang_q     <= gang_strap_pin;
         report_n_q <= power_report_strap_pin;
      end else if (load_take) begin
         gang_q     <= eeprom_load_data[`HDC_BIT_GANG];
         report_n_q <= eeprom_load_data[`HDC_BIT_REPORT_DISABLE_N];
      end else if (smbus_take) begin
         gang_q     <= smbus_write_data[`HDC_BIT_GANG];
         report_n_q <= smbus_write_data[`HDC_BIT_REPORT_DISABLE_N];
      end
   end

   // Bits with no strap: reset value until loaded or written
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lp_disable_q <= `HDC_RST_LP_DISABLE;
         tmo_ovr_q    <= `HDC_RST_TIMEOUT_OVERRIDE;
         serial_wr_q  <= `HDC_RST_SERIAL_WRITABLE;
      end else if (load_take) begin
         lp_disable_q <= eeprom_load_data[`HDC_BIT_LP_DISABLE];
         tmo_ovr_q    <= eeprom_load_data[`HDC_BIT_TIMEOUT_OVERRIDE];
         serial_wr_q  <= eeprom_load_data[`HDC_BIT_SERIAL_WRITABLE];
      end else if (smbus_take) begin
         lp_disable_q <= smbus_write_data[`HDC_BIT_LP_DISABLE];
         tmo_ovr_q    <= smbus_write_data[`HDC_BIT_TIMEOUT_OVERRIDE];
         serial_wr_q  <= smbus_write_data[`HDC_BIT_SERIAL_WRITABLE];
      end
   end

   // Read image; bit 4 is constant and ignores every write
   always_comb begin
      read_d = '0;
      read_d[`HDC_BIT_STRINGS]          = `HDC_UNCOVERED_BIT_VALUE;
      read_d[`HDC_BIT_SERIAL_WRITABLE]  = serial_wr_q;
      read_d[`HDC_BIT_LP_DISABLE]       = lp_disable_q;
      read_d[`HDC_BIT_RSVD_ONE]         = `HDC_RSVD_ONE_VALUE;
      read_d[`HDC_BIT_GANG]             = gang_q;
      read_d[`HDC_BIT_REPORT_DISABLE_N] = report_n_q;
      read_d[`HDC_BIT_TIMEOUT_OVERRIDE] = tmo_ovr_q;
      read_d[`HDC_BIT_RSVD_ZERO]        = `HDC_RSVD_ZERO_VALUE;
   end

   // Registered copy lags the bits by one cycle; the host must allow for it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         smbus_read_data <= '0;
         smbus_read_data[`HDC_BIT_RSVD_ONE] <= `HDC_RSVD_ONE_VALUE;
      end else begin
         smbus_read_data <= read_d;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_ready <= 1'b0;
      end else begin
         cfg_ready <= (state_q == hdc_pkg::HDC_CFG_READY);
      end
   end

   assign serial_string_writable     = serial_wr_q;
   assign link_low_power_disable     = lp_disable_q;
   assign low_power_timeout_override = tmo_ovr_q;

   // Per-port downstream timeout, stored raw so clearing the override restores it
   for (genvar p = 0; p < DOWN_PORTS; p++) begin : g_tmo
      logic [TMO_W-1:0] raw_q;
      logic [TMO_W-1:0] eff_q;
      logic [TMO_W-1:0] eff_d;

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            raw_q <= `HDC_TIMEOUT_DISABLED;
         end else if (host_timeout_write && (host_timeout_port == p)) begin
            raw_q <= host_timeout_value;
         end
      end

      always_comb begin
         eff_d = raw_q;
         if (tmo_ovr_q && timeout_feature_enable
             && (raw_q != `HDC_TIMEOUT_DISABLED)) begin
            eff_d = `HDC_TIMEOUT_MAX;
         end
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            eff_q <= `HDC_TIMEOUT_DISABLED;
         end else begin
            eff_q <= eff_d;
         end
      end

      assign effective_timeout[p*TMO_W +: TMO_W] = eff_q;
   end

   hdc_link_pm_gate #(
      .PORTS (DOWN_PORTS + 1)
   ) u_link_pm (
      .clk                    (clk),
      .rst                    (rst),
      .link_low_power_disable (lp_disable_q),
      .force_accept_lmp       (force_accept_lmp),
      .upstream_disconnect    (upstream_disconnect),
      .lp_request_in          (lp_request_in),
      .lp_initiate_want       (lp_initiate_want),
      .lp_request_accept      (lp_request_accept),
      .lp_initiate_go         (lp_initiate_go),
      .lp_forced              (lp_forced)
   );

   hdc_port_power #(
      .PORTS (DOWN_PORTS)
   ) u_port_power (
      .clk                    (clk),
      .rst                    (rst),
      .gang                   (gang_q),
      .report_disable_n       (report_n_q),
      .port_power_request     (port_power_request),
      .port_power_enable_pins (port_power_enable_pins),
      .power_status_report_en (power_status_report_en)
   );

endmodule // hdc_config_bits

`default_nettype wire

// >>> src/hdc_link_pm_gate.sv
// Gate for U1/U2 link low-power requests across all hub ports
`timescale 1ns/1ps
`default_nettype none

module hdc_link_pm_gate #(
   parameter int PORTS = 5
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // Configuration and link events
   input  wire logic               link_low_power_disable,
   input  wire logic               force_accept_lmp,
   input  wire logic               upstream_disconnect,
   // Per-port requests
   input  wire logic [PORTS-1:0]   lp_request_in,
   input  wire logic [PORTS-1:0]   lp_initiate_want,
   output logic      [PORTS-1:0]   lp_request_accept,
   output logic      [PORTS-1:0]   lp_initiate_go,
   output logic                    lp_forced
);

   hdc_pkg::hdc_lpm_state_type state_q;
   logic                       lp_allowed;

   // Forced state is left only by reset (power-on) or upstream disconnect
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= hdc_pkg::HDC_LPM_FOLLOW_BIT;
      end else begin
         case (state_q)
            hdc_pkg::HDC_LPM_FOLLOW_BIT: begin
               if (force_accept_lmp && !upstream_disconnect) begin
                  state_q <= hdc_pkg::HDC_LPM_FORCED;
               end
            end
            hdc_pkg::HDC_LPM_FORCED: begin
               if (upstream_disconnect) begin
                  state_q <= hdc_pkg::HDC_LPM_FOLLOW_BIT;
               end
            end
            default: state_q <= hdc_pkg::HDC_LPM_FOLLOW_BIT;
         endcase
      end
   end

   // Zero in the disable bit enables U1/U2; the escape also counts in its own cycle
   assign lp_allowed = !link_low_power_disable || (state_q == hdc_pkg::HDC_LPM_FORCED)
                       || force_accept_lmp;

   assign lp_request_accept = lp_allowed ? lp_request_in : '0;
   assign lp_initiate_go    = lp_allowed ? lp_initiate_want : '0;
   assign lp_forced         = (state_q == hdc_pkg::HDC_LPM_FORCED);

endmodule // hdc_link_pm_gate

`default_nettype wire

// >>> src/hdc_pkg.sv
// Types shared by the hub device configuration logic
package hdc_pkg;

   typedef enum logic [1:0] {
      HDC_MODE_PINS  = 2'b00,
      HDC_MODE_I2C   = 2'b01,
      HDC_MODE_SMBUS = 2'b10
   } hdc_mode_type;

   typedef enum logic [1:0] {
      HDC_CFG_STRAP = 2'b00,
      HDC_CFG_LOAD  = 2'b01,
      HDC_CFG_READY = 2'b10
   } hdc_cfg_state_type;

   typedef enum logic {
      HDC_LPM_FOLLOW_BIT = 1'b0,
      HDC_LPM_FORCED     = 1'b1
   } hdc_lpm_state_type;

endpackage : hdc_pkg

// >>> src/hdc_port_power.sv
// Downstream port power switching, individual or ganged
`timescale 1ns/1ps
`default_nettype none

module hdc_port_power #(
   parameter int PORTS = 4
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Configuration
   input  wire logic             gang,
   input  wire logic             report_disable_n,
   // Hub port power state
   input  wire logic [PORTS-1:0] port_power_request,
   output logic      [PORTS-1:0] port_power_enable_pins,
   output logic                  power_status_report_en
);

   logic [PORTS-1:0] pins_d;

   always_comb begin
      pins_d = '0;
      if (gang) begin
         // One switch serves every port, so any port asking powers them all
         pins_d[0] = |port_power_request;
      end else begin
         pins_d = port_power_request;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port_power_enable_pins <= '0;
         power_status_report_en <= 1'b0;
      end else begin
         port_power_enable_pins <= pins_d;
         power_status_report_en <= !report_disable_n;
      end
   end

endmodule // hdc_port_power

`default_nettype wire

// >>> src/hdc_regs.svh
// Bit positions, reset values and constants of the hub device configuration byte
`ifndef HDC_REGS_SVH
`define HDC_REGS_SVH

`define HDC_CFG_WIDTH            8
`define HDC_BIT_STRINGS          7
`define HDC_BIT_SERIAL_WRITABLE  6
`define HDC_BIT_LP_DISABLE       5
`define HDC_BIT_RSVD_ONE         4
`define HDC_BIT_GANG             3
`define HDC_BIT_REPORT_DISABLE_N 2
`define HDC_BIT_TIMEOUT_OVERRIDE 1
`define HDC_BIT_RSVD_ZERO        0

`define HDC_RST_SERIAL_WRITABLE  1'h0
`define HDC_RST_LP_DISABLE       1'h0
`define HDC_RST_GANG             1'h0
`define HDC_RST_REPORT_DISABLE_N 1'h0
`define HDC_RST_TIMEOUT_OVERRIDE 1'h0
`define HDC_RSVD_ONE_VALUE       1'h1
`define HDC_RSVD_ZERO_VALUE      1'h0
`define HDC_UNCOVERED_BIT_VALUE  1'h0

`define HDC_TIMEOUT_WIDTH        8
`define HDC_TIMEOUT_DISABLED     8'h00
`define HDC_TIMEOUT_MAX          8'hFF
`define HDC_DOWN_PORTS           4

`endif

// >>> tb/hdc_cfg_host.sv
// Configuration source model: SMBus host writes and EEPROM byte loads
`timescale 1ns/1ps
`default_nettype none
`include "hdc_regs.svh"
module hdc_cfg_host (
   // Clock
   input  wire logic                      clk,
   // Byte transfers
   output logic                           smbus_write,
   output logic [`HDC_CFG_WIDTH-1:0]      smbus_write_data,
   output logic                           eeprom_load_valid,
   output logic [`HDC_CFG_WIDTH-1:0]      eeprom_load_data
);
   initial begin
      smbus_write = 1'h0;
      eeprom_load_valid = 1'h0;
      smbus_write_data = 8'h00;
      eeprom_load_data = 8'hFF;
   end
   // One whole byte per strobe; idle data is inverted so stale values never match
   task automatic send(input logic eeprom, input logic [`HDC_CFG_WIDTH-1:0] d);
      @(posedge clk);
      smbus_write <= !eeprom;
      eeprom_load_valid <= eeprom;
      smbus_write_data <= eeprom ? ~d : d;
      eeprom_load_data <= eeprom ? d : ~d;
      @(posedge clk);
      smbus_write <= 1'h0;
      eeprom_load_valid <= 1'h0;
      smbus_write_data <= ~d;
      eeprom_load_data <= ~d;
   endtask
endmodule // hdc_cfg_host
`default_nettype wire

// >>> tb/hdc_config_bits_asserts.sv
// Port-level checks of the hub device configuration byte
`timescale 1ns/1ps
`default_nettype none
`include "hdc_regs.svh"
module hdc_config_bits_asserts #(
   parameter int DOWN_PORTS = `HDC_DOWN_PORTS
) (
   // Clock and reset
   input wire logic                      clk,
   input wire logic                      rst,
   // Configuration source and image
   input wire hdc_pkg::hdc_mode_type     cfg_mode,
   input wire logic                      eeprom_load_valid,
   input wire logic [`HDC_CFG_WIDTH-1:0] eeprom_load_data,
   input wire logic                      smbus_write,
   input wire logic [`HDC_CFG_WIDTH-1:0] smbus_write_data,
   input wire logic [`HDC_CFG_WIDTH-1:0] smbus_read_data,
   input wire logic                      link_low_power_disable,
   // Link power management
   input wire logic                      force_accept_lmp,
   input wire logic                      upstream_disconnect,
   input wire logic [DOWN_PORTS:0]       lp_request_in,
   input wire logic [DOWN_PORTS:0]       lp_initiate_want,
   input wire logic [DOWN_PORTS:0]       lp_request_accept,
   input wire logic [DOWN_PORTS:0]       lp_initiate_go,
   input wire logic                      lp_forced,
   // Port power
   input wire logic [DOWN_PORTS-1:0]     port_power_request,
   input wire logic [DOWN_PORTS-1:0]     port_power_enable_pins,
   input wire logic                      power_status_report_en
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic permit;
   assign permit = !link_low_power_disable || lp_forced || force_accept_lmp;
   // Disconnect in the same cycle as an LMP is left open, so it is excluded
   lp_accept_gate_a: assert property (!upstream_disconnect |-> lp_request_accept ==
      (lp_request_in & {(DOWN_PORTS+1){permit}})) else $error("accept gating wrong");
   lp_go_gate_a: assert property (!upstream_disconnect |-> lp_initiate_go ==
      (lp_initiate_want & {(DOWN_PORTS+1){permit}})) else $error("initiate gating wrong");
   force_latch_a: assert property (force_accept_lmp && !upstream_disconnect ##1
      !upstream_disconnect [*3] |-> lp_forced) else $error("force accept not held");
   disc_clear_a: assert property (upstream_disconnect |=> !lp_forced)
      else $error("disconnect did not clear force");
   rsvd_one_a: assert property (smbus_read_data[4]) else $error("reserved bit not one");
   // The first edge after release still shows reset values on both registered copies
   gang_pins_a: assert property (!$past(rst) |->
      port_power_enable_pins == (smbus_read_data[3] ?
      {{(DOWN_PORTS-1){1'b0}}, |$past(port_power_request)} : $past(port_power_request)))
      else $error("power pins wrong");
   report_en_a: assert property (!$past(rst) |->
      power_status_report_en == !smbus_read_data[2])
      else $error("report enable wrong");
   smbus_write_a: assert property (smbus_write && cfg_mode == hdc_pkg::HDC_MODE_SMBUS &&
      !$past(rst) |=> link_low_power_disable == $past(smbus_write_data[5]))
      else $error("smbus write not taken");
   eeprom_load_a: assert property (eeprom_load_valid && cfg_mode == hdc_pkg::HDC_MODE_I2C &&
      !$past(rst) |=> link_low_power_disable == $past(eeprom_load_data[5]))
      else $error("eeprom load not taken");
   smbus_refuse_a: assert property (smbus_write && !eeprom_load_valid &&
      cfg_mode == hdc_pkg::HDC_MODE_I2C |=> $stable(link_low_power_disable))
      else $error("smbus write taken in i2c mode");
endmodule // hdc_config_bits_asserts
`default_nettype wire

// >>> tb/tb_hdc_config_bits.sv
// Self-checking bench of the hub device configuration byte
`timescale 1ns/1ps
`default_nettype none
`include "hdc_regs.svh"
module tb_hdc_config_bits;
   logic                  clk, rst, gang_strap_pin, power_report_strap_pin, cfg_ready;
   hdc_pkg::hdc_mode_type cfg_mode;
   logic                  eeprom_load_valid, smbus_write, force_accept_lmp, upstream_disconnect;
   logic [7:0]            eeprom_load_data, smbus_write_data, smbus_read_data, host_timeout_value;
   logic                  serial_string_writable, link_low_power_disable, lp_forced;
   logic                  low_power_timeout_override, timeout_feature_enable, host_timeout_write;
   logic [4:0]            lp_request_in, lp_initiate_want, lp_request_accept, lp_initiate_go;
   logic [1:0]            host_timeout_port;
   logic [31:0]           effective_timeout;
   logic [3:0]            port_power_request, port_power_enable_pins;
   logic                  power_status_report_en;
   int                    num_errors, n_checks;
   logic [7:0] wd[5] = '{8'h2C, 8'hFF, 8'h00, 8'h42, 8'h08};
   logic [3:0] rq[5] = '{4'h5, 4'h0, 4'hA, 4'h6, 4'h8};
   logic [7:0] rd[5] = '{8'h3C, 8'h7E, 8'h10, 8'h52, 8'h18};
   logic [3:0] pn[5] = '{4'h1, 4'h0, 4'hA, 4'h6, 4'h1};
   logic [7:0] tv[4] = '{8'h01, 8'h00, 8'hFF, 8'h7F};
   logic [7:0] te[4] = '{8'hFF, 8'h00, 8'hFF, 8'h7F};
   hdc_config_bits dut (.clk, .rst, .gang_strap_pin, .power_report_strap_pin, .cfg_mode,
      .eeprom_load_valid, .eeprom_load_data, .smbus_write, .smbus_write_data, .smbus_read_data,
      .cfg_ready, .serial_string_writable, .link_low_power_disable, .low_power_timeout_override,
      .force_accept_lmp, .upstream_disconnect, .lp_request_in, .lp_initiate_want,
      .lp_request_accept, .lp_initiate_go, .lp_forced, .timeout_feature_enable,
      .host_timeout_write, .host_timeout_port, .host_timeout_value, .effective_timeout,
      .port_power_request, .port_power_enable_pins, .power_status_report_en);
   hdc_cfg_host host (.clk, .smbus_write, .smbus_write_data, .eeprom_load_valid,
      .eeprom_load_data);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Straps flip right after capture, so only the release-time level may show
   task automatic do_reset(input hdc_pkg::hdc_mode_type m, input logic g, input logic p);
      @(posedge clk);
      rst <= 1'b1;
      cfg_mode <= m;
      gang_strap_pin <= g;
      power_report_strap_pin <= p;
      repeat (20) @(posedge clk);
      @(negedge clk) check(smbus_read_data, 8'h10);
      @(posedge clk) rst <= 1'b0;
      @(posedge clk);
      gang_strap_pin <= !g;
      power_report_strap_pin <= !p;
      for (int i = 0; i < 10 && cfg_ready !== 1'b1 && m != hdc_pkg::HDC_MODE_I2C; i++)
         @(negedge clk);
      repeat (3) @(negedge clk);
      if (m != hdc_pkg::HDC_MODE_I2C && cfg_ready !== 1'b1) begin
         num_errors++;
         test_done();
      end else begin
         check(smbus_read_data, {4'h1, g, p, 2'h0});
      end
   endtask
   task automatic settle();
      @(posedge clk);
      @(negedge clk);
   endtask
   initial begin
      rst = 1'b1;
      cfg_mode = hdc_pkg::HDC_MODE_SMBUS;
      {gang_strap_pin, power_report_strap_pin, force_accept_lmp, upstream_disconnect} = 4'h0;
      {timeout_feature_enable, host_timeout_write, host_timeout_port} = 4'h0;
      {lp_request_in, lp_initiate_want, port_power_request, host_timeout_value} = 22'h0;
      num_errors = 0;
      n_checks = 0;
      do_reset(hdc_pkg::HDC_MODE_SMBUS, 1'b1, 1'b0);
      for (int i = 0; i < 5; i++) begin
         @(posedge clk) port_power_request <= rq[i];
         host.send(1'b0, wd[i]);
         settle();
         check(smbus_read_data, rd[i]);
         check(port_power_enable_pins, pn[i]);
         check(power_status_report_en, !wd[i][2]);
         check({serial_string_writable, link_low_power_disable, low_power_timeout_override},
            {wd[i][6], wd[i][5], wd[i][1]});
      end
      host.send(1'b0, 8'h20);
      lp_request_in <= 5'h1F;
      lp_initiate_want <= 5'h15;
      @(negedge clk) check({lp_request_accept, lp_initiate_go}, 10'h0);
      @(posedge clk) force_accept_lmp <= 1'b1;
      @(negedge clk) check(lp_request_accept, 5'h1F);
      @(posedge clk) force_accept_lmp <= 1'b0;
      repeat (3) @(negedge clk) check({lp_forced, lp_initiate_go}, 6'h35);
      @(posedge clk) upstream_disconnect <= 1'b1;
      @(posedge clk) upstream_disconnect <= 1'b0;
      @(negedge clk) check({lp_forced, lp_request_accept}, 6'h0);
      host.send(1'b0, 8'h02);
      @(negedge clk) check(lp_request_accept, 5'h1F);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         timeout_feature_enable <= (i != 3);
         host_timeout_write <= 1'b1;
         host_timeout_port <= i[1:0];
         host_timeout_value <= tv[i];
         @(posedge clk) host_timeout_write <= 1'b0;
         settle();
         check(effective_timeout[8*i +: 8], te[i]);
      end
      do_reset(hdc_pkg::HDC_MODE_I2C, 1'b0, 1'b1);
      host.send(1'b1, 8'h28);
      settle();
      check(smbus_read_data, 8'h38);
      check(cfg_ready, 1'b1);
      host.send(1'b0, 8'h00);
      settle();
      check(smbus_read_data, 8'h38);
      // Pin mode: straps only, neither source may change the byte
      do_reset(hdc_pkg::HDC_MODE_PINS, 1'b1, 1'b1);
      host.send(1'b0, 8'h20);
      host.send(1'b1, 8'h20);
      settle();
      check(smbus_read_data, 8'h1C);
      check(port_power_enable_pins, {3'h0, |rq[4]});
      test_done();
   end
endmodule // tb_hdc_config_bits
bind hdc_config_bits hdc_config_bits_asserts #(.DOWN_PORTS(DOWN_PORTS)) u_chk (.clk, .rst,
   .cfg_mode, .eeprom_load_valid, .eeprom_load_data, .smbus_write, .smbus_write_data,
   .smbus_read_data, .link_low_power_disable, .force_accept_lmp, .upstream_disconnect,
   .lp_request_in, .lp_initiate_want, .lp_request_accept, .lp_initiate_go, .lp_forced,
   .port_power_request, .port_power_enable_pins, .power_status_report_en);
`default_nettype wire
